//--- shared/io_window_map.svh
`ifndef IO_WINDOW_MAP_SVH
`define IO_WINDOW_MAP_SVH
`define IOW_DWORD_OFFSET   8'h1c
`define IOW_WIDTH_CODE     4'h1
`define IOW_NIB_RESET      4'h0
`define IOW_BOT_CODE_LSB   0
`define IOW_BOT_ADDR_LSB   4
`define IOW_TOP_CODE_LSB   8
`define IOW_TOP_ADDR_LSB   12
`define SST_RSVD_LO_LSB    16
`define SST_SPEED_BIT      21
`define SST_RSVD_HI_BIT    22
`define SST_FAST_B2B_BIT   23
`define SST_DATA_PAR_BIT   24
`define SST_SEL_TIME_LSB   25
`define SST_SEL_TIME_CODE  2'h1
`define SST_SIG_TABT_BIT   27
`define SST_RCV_TABT_BIT   28
`define SST_RCV_MABT_BIT   29
`define SST_RCV_SERR_BIT   30
`define SST_DET_PERR_BIT   31
`define SST_FLAG_RESET     8'h00
`define IOW_GRAIN_BITS     12
`endif

//--- shared/io_window_pkg.sv
package io_window_pkg;
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] offset;
    logic [3:0] byte_en_b;
    logic [31:0] wdata;
  } cfg_req_s;
  typedef struct packed {
    logic master_on_sec;
    logic par_err_seen;
    logic primary_par_err;
    logic par_resp_en;
    logic sig_target_abort;
    logic rcv_target_abort;
    logic rcv_master_abort;
    logic addr_data_par_err;
  } sec_events_s;
  typedef logic [7:0] err_flags_t;
endpackage

//--- hdl/io_window_match.sv
`timescale 1ns/1ns
`include "io_window_map.svh"
module io_window_match #(
  parameter int ADDR_W = 32
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [15:0]       bottom_upper,
  input  wire logic [15:0]       top_upper,
  input  wire logic [3:0]        bottom_nib,
  input  wire logic [3:0]        top_nib,
  output wire logic              hit
);
  wire logic [ADDR_W-1:0] bottom;
  wire logic [ADDR_W-1:0] top;
  assign bottom = {bottom_upper, bottom_nib, 12'h000};
  assign top    = {top_upper, top_nib, 12'hfff};
  assign hit    = (addr >= bottom) && (addr <= top);
endmodule

//--- hdl/io_window_secondary_status.sv
`timescale 1ns/1ns
`include "io_window_map.svh"
// Operation
// - Base low nibble reads 1h
// - Base upper nibble writable, address 15:12
// - Limit nibble reads 1h, upper writable
// - Address 31:16 from upper registers
// - Window aligned, sized in 4 kB
// - Window decides I/O forwarding
// - Write one clears flag, zero keeps
// - Reserved status bits read zero
// - Bit 21 shows speed strap level
// - Bit 23 reads one
// - Bit 24 set on qualified parity error
// - Bits 26:25 read 01b
// - Bit 27 on signalled target abort
// - Bit 28 on received target abort
// - Bit 29 on received master abort
// - Bit 30 on system error pin
// - Bit 31 on parity error; flags reset zero
module io_window_secondary_status
  import io_window_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        cfg_write,
  input  wire logic        cfg_read,
  input  wire logic [7:0]  cfg_offset,
  input  wire logic [3:0]  primary_byte_enables,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  input  wire logic        speed_strap_pin,
  input  wire logic        secondary_parity_error_pin_b,
  input  wire logic        secondary_system_error_pin_b,
  input  wire sec_events_s sec_events,
  input  wire logic [15:0] io_bottom_upper,
  input  wire logic [15:0] io_top_upper,
  input  wire logic [31:0] io_addr,
  output wire logic        io_forward
);
  logic [3:0] bottom_nib;
  logic [3:0] top_nib;
  err_flags_t flags;
  logic [2:0] strap_sync;
  logic       speed_bit;
  logic [2:0] perr_sync;
  logic [2:0] serr_sync;
  logic       perr_seen;
  logic       serr_seen;

  wire logic       sel_dword;
  wire logic       wr_b0;
  wire logic       wr_b1;
  wire logic       wr_b3;
  wire logic [5:0] set_vec;
  wire logic       set_dpar;
  wire logic       set_serr;
  wire err_flags_t clr_vec;
  wire err_flags_t next_flags;
  wire logic [31:0] read_word;

  assign sel_dword = (cfg_offset == `IOW_DWORD_OFFSET);
  assign wr_b0 = cfg_write && sel_dword && !primary_byte_enables[0];
  assign wr_b1 = cfg_write && sel_dword && !primary_byte_enables[1];
  assign wr_b3 = cfg_write && sel_dword && !primary_byte_enables[3];

  // Pin inputs: three stages, change accepted when stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      strap_sync <= 3'h0;
      perr_sync  <= 3'h7;
      serr_sync  <= 3'h7;
      speed_bit  <= 1'b0;
      perr_seen  <= 1'b0;
      serr_seen  <= 1'b0;
    end
    else if (clk_en)
    begin
      strap_sync <= {strap_sync[1:0], speed_strap_pin};
      perr_sync  <= {perr_sync[1:0], secondary_parity_error_pin_b};
      serr_sync  <= {serr_sync[1:0], secondary_system_error_pin_b};
      if (strap_sync[1] == strap_sync[2])
        speed_bit <= strap_sync[2];
      if (perr_sync[1] == perr_sync[2])
        perr_seen <= !perr_sync[2];
      if (serr_sync[1] == serr_sync[2])
        serr_seen <= !serr_sync[2];
    end
  end

  // Error flags are bits 31:24 of the dword, indexed from bit 24
  assign set_dpar = sec_events.master_on_sec && sec_events.par_resp_en &&
                    (perr_seen || sec_events.primary_par_err ||
                     sec_events.par_err_seen);
  assign set_serr = serr_seen;
  assign set_vec = {sec_events.addr_data_par_err,
                    set_serr,
                    sec_events.rcv_master_abort,
                    sec_events.rcv_target_abort,
                    sec_events.sig_target_abort,
                    set_dpar};
  assign clr_vec = wr_b3 ? cfg_wdata[31:24] : 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      if (gi == 0 || gi >= 3)
      begin : g_live
        localparam int SI = (gi == 0) ? 0 : gi - 2;
        // Set wins over a clear in the same cycle
        assign next_flags[gi] = set_vec[SI] | (flags[gi] & ~clr_vec[gi]);
      end
      else
      begin : g_const
        assign next_flags[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      bottom_nib <= `IOW_NIB_RESET;
      top_nib    <= `IOW_NIB_RESET;
      flags      <= `SST_FLAG_RESET;
    end
    else if (clk_en)
    begin
      if (wr_b0)
        bottom_nib <= cfg_wdata[`IOW_BOT_ADDR_LSB +: 4];
      if (wr_b1)
        top_nib <= cfg_wdata[`IOW_TOP_ADDR_LSB +: 4];
      flags <= next_flags;
    end
  end

  assign read_word = {flags[7:3],
                      `SST_SEL_TIME_CODE,
                      flags[0],
                      1'b1,
                      1'b0,
                      speed_bit,
                      5'h00,
                      top_nib,
                      `IOW_WIDTH_CODE,
                      bottom_nib,
                      `IOW_WIDTH_CODE};

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      cfg_rdata <= 32'h0000_0000;
    else if (clk_en && cfg_read)
      cfg_rdata <= sel_dword ? read_word : 32'h0000_0000;
  end

  // Software must program the base before relying on forwarding
  io_window_match #(
    .ADDR_W(32)
  ) u_match (
    .addr         (io_addr),
    .bottom_upper (io_bottom_upper),
    .top_upper    (io_top_upper),
    .bottom_nib   (bottom_nib),
    .top_nib      (top_nib),
    .hit          (io_forward)
  );

  property p_clear_one;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && wr_b3 && cfg_wdata[31] && !sec_events.addr_data_par_err && flags[7])
      |=> !flags[7];
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("W1C bit 31 not cleared");

  property p_keep_zero;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && flags[5] && !(wr_b3 && cfg_wdata[29])) |=> flags[5];
  endproperty
  a_keep_zero: assert property (p_keep_zero) else $error("Flag lost without clear");

  property p_dpar_cause;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && $rose(flags[0])) |-> $past(set_dpar);
  endproperty
  a_dpar_cause: assert property (p_dpar_cause) else $error("Bit 24 set without cause");

  property p_sig_tabt;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && sec_events.sig_target_abort) |=> flags[3];
  endproperty
  a_sig_tabt: assert property (p_sig_tabt) else $error("Bit 27 not set");

  property p_rcv_tabt;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && sec_events.rcv_target_abort) |=> flags[4];
  endproperty
  a_rcv_tabt: assert property (p_rcv_tabt) else $error("Bit 28 not set");

  property p_mabt;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && sec_events.rcv_master_abort) |=> flags[5];
  endproperty
  a_mabt: assert property (p_mabt) else $error("Bit 29 not set");

  sequence s_serr_low;
    !secondary_system_error_pin_b && clk_en;
  endsequence
  property p_serr;
    @(posedge clk) disable iff (!rst_b)
      s_serr_low [*4] |-> ##2 flags[6];
  endproperty
  a_serr: assert property (p_serr) else $error("Bit 30 not set on system error");

  property p_const_bits;
    @(posedge clk) disable iff (!rst_b)
      (cfg_read && sel_dword && clk_en) |=>
        (cfg_rdata[3:0] == 4'h1 && cfg_rdata[11:8] == 4'h1 && cfg_rdata[26:25] == 2'h1
         && cfg_rdata[23] && cfg_rdata[22] == 1'b0 && cfg_rdata[20:16] == 5'h00);
  endproperty
  a_const_bits: assert property (p_const_bits) else $error("Fixed bits wrong");

  property p_bytelane;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && cfg_write && primary_byte_enables[0]) |=> $stable(bottom_nib);
  endproperty
  a_bytelane: assert property (p_bytelane) else $error("Disabled lane written");

  property p_fwd;
    @(posedge clk) disable iff (!rst_b)
      (io_addr == {io_bottom_upper, bottom_nib, 12'h000} &&
       {io_bottom_upper, bottom_nib} <= {io_top_upper, top_nib}) |-> io_forward;
  endproperty
  a_fwd: assert property (p_fwd) else $error("Bottom address not forwarded");

  property p_fwd_top;
    @(posedge clk) disable iff (!rst_b)
      (io_addr == {io_top_upper, top_nib, 12'hfff} &&
       {io_bottom_upper, bottom_nib} <= {io_top_upper, top_nib}) |-> io_forward;
  endproperty
  a_fwd_top: assert property (p_fwd_top) else $error("Top address not forwarded");

  property p_fwd_below;
    @(posedge clk) disable iff (!rst_b)
      ({io_bottom_upper, bottom_nib} != 20'h00000 &&
       io_addr == {io_bottom_upper, bottom_nib, 12'h000} - 32'h0000_0001) |-> !io_forward;
  endproperty
  a_fwd_below: assert property (p_fwd_below) else $error("Below window forwarded");

  property p_top_lane;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && cfg_write && primary_byte_enables[1]) |=> $stable(top_nib);
  endproperty
  a_top_lane: assert property (p_top_lane) else $error("Limit lane written");

  property p_flag_lane;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && !wr_b3 && flags[3]) |=> flags[3];
  endproperty
  a_flag_lane: assert property (p_flag_lane) else $error("Flag lost off lane");

  property p_base_write;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && wr_b0) |=> (bottom_nib == $past(cfg_wdata[7:4]));
  endproperty
  a_base_write: assert property (p_base_write) else $error("Base not written");

  property p_top_write;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && wr_b1) |=> (top_nib == $past(cfg_wdata[15:12]));
  endproperty
  a_top_write: assert property (p_top_write) else $error("Limit not written");

  property p_unmapped;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && cfg_read && !sel_dword) |=> (cfg_rdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero");

  property p_window_read;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && cfg_read && sel_dword) |=>
        (cfg_rdata[7:4] == $past(bottom_nib) && cfg_rdata[15:12] == $past(top_nib));
  endproperty
  a_window_read: assert property (p_window_read) else $error("Window misread");

  property p_speed_read;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && cfg_read && sel_dword) |=> (cfg_rdata[21] == $past(speed_bit));
  endproperty
  a_speed_read: assert property (p_speed_read) else $error("Strap misread");

  property p_flag_read;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && cfg_read && sel_dword) |=>
        (cfg_rdata[31:27] == $past(flags[7:3]) && cfg_rdata[24] == $past(flags[0]));
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("Flags misread");

  property p_dpar_need;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && !flags[0] && !(sec_events.master_on_sec && sec_events.par_resp_en))
        |=> !flags[0];
  endproperty
  a_dpar_need: assert property (p_dpar_need) else $error("Bit 24 set unqualified");

  property p_freeze;
    @(posedge clk) disable iff (!rst_b)
      !clk_en |=> ($stable(flags) && $stable(bottom_nib) && $stable(top_nib)
                   && $stable(cfg_rdata) && $stable(speed_bit));
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved while disabled");
endmodule

//--- verif/far_side_agent.sv
`timescale 1ns/1ns
module far_side_agent
  import io_window_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [3:0] code,
  input  wire logic       go,
  output sec_events_s     ev,
  output logic            perr_b,
  output logic            serr_b
);
  // Released pins idle high, events idle low
  initial
  begin
    ev = '0;
    perr_b = 1'b1;
    serr_b = 1'b1;
  end
  always @(posedge clk)
  begin
    ev <= '0;
    perr_b <= 1'b1;
    serr_b <= 1'b1;
    if (go)
    begin
      case (code)
        4'h0: ev.sig_target_abort <= 1'b1;
        4'h1: ev.rcv_target_abort <= 1'b1;
        4'h2: ev.rcv_master_abort <= 1'b1;
        4'h3: serr_b <= 1'b0;
        4'h4: ev.addr_data_par_err <= 1'b1;
        4'h5: ev <= 8'hd0;
        4'h6:
        begin
          ev <= 8'h90;
          perr_b <= 1'b0;
        end
        4'h7: ev <= 8'he0;
        4'h8: ev <= 8'h70;
        default: ev <= 8'hb0;
      endcase
    end
  end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import io_window_pkg::*;
  typedef struct packed {
    logic [3:0]  b;
    logic [3:0]  t;
    logic [15:0] bu;
    logic [15:0] tu;
    logic [31:0] a;
    logic        f;
  } row_s;
  localparam row_s rows [7] = '{
    '{4'h2, 4'h3, 16'h0, 16'h0, 32'h2000, 1'b1}, '{4'h2, 4'h3, 16'h0, 16'h0, 32'h1fff, 1'b0},
    '{4'h2, 4'h3, 16'h0, 16'h0, 32'h3fff, 1'b1}, '{4'h2, 4'h3, 16'h0, 16'h0, 32'h4000, 1'b0},
    '{4'h0, 4'h0, 16'h1, 16'h1, 32'h10fff, 1'b1}, '{4'h0, 4'h0, 16'h1, 16'h1, 32'h11000, 1'b0},
    '{4'h0, 4'h0, 16'h1, 16'h1, 32'h0fff, 1'b0}};
  localparam logic [7:0] flag_exp [10] = '{8'h0a, 8'h12, 8'h22, 8'h42, 8'h82,
                                           8'h03, 8'h03, 8'h02, 8'h02, 8'h03};
  localparam logic [31:0] RST_WORD = 32'h02a00101;
  logic        clk, rst_b, cfg_write, cfg_read, speed_strap_pin, go, perr_b, serr_b, io_forward;
  logic        clk_en;
  logic [7:0]  cfg_offset, care;
  logic [3:0]  primary_byte_enables, code;
  logic [31:0] cfg_wdata, cfg_rdata, io_addr;
  logic [15:0] io_bottom_upper, io_top_upper;
  sec_events_s sec_events;
  int          n_fail, tests_run;
  io_window_secondary_status dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_offset(cfg_offset),
    .primary_byte_enables(primary_byte_enables),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .speed_strap_pin(speed_strap_pin),
    .secondary_parity_error_pin_b(perr_b), .secondary_system_error_pin_b(serr_b),
    .sec_events(sec_events), .io_bottom_upper(io_bottom_upper), .io_top_upper(io_top_upper),
    .io_addr(io_addr), .io_forward(io_forward));
  far_side_agent partner (.clk(clk), .code(code), .go(go), .ev(sec_events), .perr_b(perr_b),
    .serr_b(serr_b));
  always #10 clk = ~clk;
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task cfg(input logic w, input logic [7:0] off, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfg_write <= w;
    cfg_read <= !w;
    cfg_offset <= off;
    primary_byte_enables <= be;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_write <= 1'b0;
    cfg_read <= 1'b0;
    #1;
  endtask
  task tally_and_finish;
    $display("Comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_fail++;
    tally_and_finish;
  end
  initial
  begin
    clk = 0; rst_b = 0; cfg_write = 0; cfg_read = 0; cfg_offset = 0; cfg_wdata = 0; go = 0;
    primary_byte_enables = 4'hf; speed_strap_pin = 1; code = 0; care = 0; io_addr = 0;
    io_bottom_upper = 0; io_top_upper = 0; n_fail = 0; tests_run = 0;
    clk_en = 1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    // Ordinary cases: program window, read back, probe forwarding
    foreach (rows[i])
    begin
      cfg(1'b1, 8'h1c, 4'b1100, {16'hffff, rows[i].t, 4'hf, rows[i].b, 4'hf});
      cfg(1'b0, 8'h1c, 4'hf, 32'h0);
      check("window word", cfg_rdata,
            {16'h02a0, rows[i].t, 4'h1, rows[i].b, 4'h1});
      @(posedge clk);
      io_bottom_upper <= rows[i].bu;
      io_top_upper <= rows[i].tu;
      io_addr <= rows[i].a;
      #1;
      check("io_forward", io_forward, rows[i].f);
    end
    $display("test window done");
    cfg(1'b0, 8'h18, 4'hf, 32'h0);
    check("unmapped", cfg_rdata, 32'h0);
    cfg(1'b1, 8'h1c, 4'b1110, 32'hffffffff);
    cfg(1'b0, 8'h1c, 4'hf, 32'h0);
    check("lane0 only", cfg_rdata, 32'h02a001f1);
    $display("test lanes done");
    @(posedge clk);
    clk_en <= 1'b0;
    cfg(1'b1, 8'h1c, 4'b1110, 32'h00000020);
    cfg(1'b0, 8'h18, 4'hf, 32'h0);
    check("frozen read", cfg_rdata, 32'h02a001f1);
    @(posedge clk);
    clk_en <= 1'b1;
    cfg(1'b0, 8'h1c, 4'hf, 32'h0);
    check("frozen write", cfg_rdata, 32'h02a001f1);
    $display("test enable done");
    for (int i = 0; i < 10; i++)
    begin
      care = (i > 4) ? 8'h7f : 8'hff;
      @(posedge clk);
      code <= 4'(i);
      go <= 1'b1;
      repeat (8) @(posedge clk);
      go <= 1'b0;
      repeat (6) @(posedge clk);
      cfg(1'b0, 8'h1c, 4'hf, 32'h0);
      check("flags set", cfg_rdata[31:24] & care,
            flag_exp[i]);
      cfg(1'b1, 8'h1c, 4'b0111, 32'h0);
      cfg(1'b0, 8'h1c, 4'hf, 32'h0);
      check("flags kept", cfg_rdata[31:24] & care, flag_exp[i]);
      cfg(1'b1, 8'h1c, 4'b0111, 32'hff000000);
      cfg(1'b0, 8'h1c, 4'hf, 32'h0);
      check("flags cleared", cfg_rdata, 32'h02a001f1);
    end
    $display("test flags done");
    @(posedge clk);
    speed_strap_pin <= 1'b0;
    code <= 4'h4;
    go <= 1'b1;
    repeat (8) @(posedge clk);
    go <= 1'b0;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    cfg(1'b0, 8'h1c, 4'hf, 32'h0);
    check("reset word", cfg_rdata,
          RST_WORD & 32'hffdfffff);
    $display("test reset done");
    tally_and_finish;
  end
endmodule
